// [core/eid_detector.sv]
// eid_detector: ten-input external interrupt detection unit
// assumes: plain config ports from an always-on register block, MCLK 125 MHz
// Operation
// - ten inputs are provided, each with its own detector and configuration.
// - a 3-bit mode selects rising, falling, either edge, high or low level.
// - codes 5, 6 and 7 behave as falling, either edge and high level.
// - rising mode sends one request pulse per low-to-high transition.
// - falling mode sends one request pulse per high-to-low transition.
// - either-edge mode sends one pulse per transition of either direction.
// - high-level mode holds the request while the input stays high.
// - low-level mode holds the request while the input stays low.
// - the unit is always on and a configured request raises wake-up.
// - an input is seen only while its pin input path is enabled.
// - a disabled input never requests, whatever its mode.
// - each input owns a 4-bit slot, mode low three bits, enable on top.
// - a one on EXT_IRQ_FLAG_CLEAR clears the flag, but a request in the same cycle wins.
// - after reset all inputs are disabled with mode zero.
`timescale 1ns/1ns
module eid_detector
    import eid_pkg::*;
#(
    parameter int N = NUM_INPUTS
)(
    input  wire logic                 MCLK,
    input  wire logic                 RESET,
    input  wire logic                 CE,
    input  wire logic [N-1:0]         EXT_IRQ_PIN,
    input  wire logic [N-1:0]         PIN_INPUT_PATH_ENABLE,
    input  wire logic                 CFG_WR,
    input  wire logic [1:0]           CFG_SEL,
    input  wire logic [CFG_W-1:0]     CFG_WDATA,
    input  wire logic [N-1:0]         EXT_IRQ_FLAG_CLEAR,
    output logic [CFG_W-1:0]          EXT_IRQ_CONFIG_LOW,
    output logic [CFG_W-1:0]          EXT_IRQ_CONFIG_MID,
    output logic [CFG_W-1:0]          EXT_IRQ_CONFIG_HIGH,
    output logic [N-1:0]              IRQ_REQ,
    output logic [N-1:0]              IRQ_FLAG,
    output logic                      WAKE
);
    import eid_pkg::*;

    initial begin
        if (N < 1 || N > CFG_REGS * (CFG_W / SLOT_W)) begin
            $error("eid_detector: N out of range");
        end
    end

    // ==========================================================
    // configuration registers, flat slots of SLOT_W bits
    localparam int TOT = CFG_REGS * CFG_W;
    logic [TOT-1:0] cfg_q;
    logic [TOT-1:0] cfg_d;
    logic [TOT-1:0] wmask;
    logic [N-1:0]   flag_q;
    logic [N-1:0]   req_w;
    logic [N-1:0]   det_w;

    // unimplemented slots are held at zero so they read back as reserved
    logic [TOT-1:0] live_mask;
    always_comb begin
        live_mask = '0;
        for (int i = 0; i < N; i++) begin
            live_mask[i*SLOT_W +: SLOT_W] = {SLOT_W{1'b1}};
        end
        wmask = '0;
        wmask[CFG_SEL*CFG_W +: CFG_W] = {CFG_W{1'b1}};
        cfg_d = (cfg_q & ~wmask) | ({CFG_REGS{CFG_WDATA}} & wmask);
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cfg_q <= {CFG_REGS{CFG_RESET}};
        end else if (CE && CFG_WR && CFG_SEL < 2'(CFG_REGS)) begin
            cfg_q <= cfg_d & live_mask;
        end
    end

    assign EXT_IRQ_CONFIG_LOW  = cfg_q[0*CFG_W +: CFG_W];
    assign EXT_IRQ_CONFIG_MID  = cfg_q[1*CFG_W +: CFG_W];
    assign EXT_IRQ_CONFIG_HIGH = cfg_q[2*CFG_W +: CFG_W];

    // ==========================================================
    // per-input detectors
    for (genvar g = 0; g < N; g++) begin : g_ch
        eid_channel u_ch (
            .clk     (MCLK),
            .rst     (RESET),
            .ce      (CE),
            .pin     (EXT_IRQ_PIN[g]),
            .path_en (PIN_INPUT_PATH_ENABLE[g]),
            .enable  (cfg_q[g*SLOT_W + ENABLE_BIT]),
            .mode    (cfg_q[g*SLOT_W + MODE_LSB +: MODE_W]),
            .req     (req_w[g]),
            .flag    (det_w[g])
        );
    end

    // ==========================================================
    // internal flags: set wins over the strobe clear
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            flag_q <= '0;
        end else if (CE) begin
            flag_q <= req_w | (flag_q & ~EXT_IRQ_FLAG_CLEAR);
        end
    end

    assign IRQ_REQ  = req_w;
    assign IRQ_FLAG = flag_q;
    assign WAKE     = |req_w;

    // ==========================================================
    // checks
    a_disabled_quiet: assert property (@(posedge MCLK) disable iff (RESET)
        (!cfg_q[ENABLE_BIT] && $past(!cfg_q[ENABLE_BIT])) |-> !req_w[0])
        else $error("disabled input requested");
    a_path_gate: assert property (@(posedge MCLK) disable iff (RESET)
        ($past(!PIN_INPUT_PATH_ENABLE[0]) && !PIN_INPUT_PATH_ENABLE[0]
         && cfg_q[2:0] != 3'h4) |-> !req_w[0])
        else $error("request with input path off");
    a_edge_single: assert property (@(posedge MCLK) disable iff (RESET)
        (CE && $past(CE) && cfg_q[2:0] == 3'h0 && req_w[0]) |=> !req_w[0])
        else $error("edge request longer than one cycle");
    a_flag_set_wins: assert property (@(posedge MCLK) disable iff (RESET)
        (CE && req_w[0]) |=> flag_q[0])
        else $error("flag lost a request");
    a_flag_clears: assert property (@(posedge MCLK) disable iff (RESET)
        (CE && EXT_IRQ_FLAG_CLEAR[0] && !req_w[0]) |=> !flag_q[0])
        else $error("flag not cleared");
    a_wake_follows: assert property (@(posedge MCLK) disable iff (RESET)
        WAKE == (req_w != '0))
        else $error("wake disagrees with requests");
    a_high_level: assert property (@(posedge MCLK) disable iff (RESET)
        (CE && $past(CE) && cfg_q[3:0] == 4'hb && PIN_INPUT_PATH_ENABLE[0]
         && $past(PIN_INPUT_PATH_ENABLE[0])
         && $past(cfg_q[3:0]) == 4'hb
         && g_ch[0].u_ch.sync2_q) |=> req_w[0])
        else $error("high level not requested");
    a_reset_cfg: assert property (@(posedge MCLK)
        $past(RESET) |-> cfg_q == '0)
        else $error("config not cleared by reset");

endmodule : eid_detector

// [common/eid_pkg.sv]
// eid_pkg: constants and types for the external interrupt detector
// assumes: included before the core files, one clock domain
package eid_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_INPUTS  = 10;
    localparam int MODE_W      = 3;
    localparam int SLOT_W      = 4;
    localparam int CFG_W       = 16;
    localparam int CFG_REGS    = 3;

    // ==========================================================
    // slot layout inside a configuration word
    localparam int MODE_LSB    = 0;
    localparam int ENABLE_BIT  = 3;

    // ==========================================================
    // reset values
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

    // ==========================================================
    // mode codes; 5..7 alias falling, either and high
    typedef enum logic [MODE_W-1:0] {
        EID_RISE      = 3'h0,
        EID_FALL      = 3'h1,
        EID_EITHER    = 3'h2,
        EID_HIGH      = 3'h3,
        EID_LOW       = 3'h4,
        EID_FALL_ALT  = 3'h5,
        EID_EITHER_ALT = 3'h6,
        EID_HIGH_ALT  = 3'h7
    } eid_mode_t;

endpackage : eid_pkg

// [core/eid_channel.sv]
// eid_channel: detector for one external interrupt input
// assumes: the pin is asynchronous to MCLK; config comes from MCLK logic
`timescale 1ns/1ns
module eid_channel
    import eid_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              pin,
    input  wire logic              path_en,
    input  wire logic              enable,
    input  wire logic [MODE_W-1:0] mode,
    output logic                   req,
    output logic                   flag
);
    // ==========================================================
    // synchroniser and edge history
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic req_q;
    logic req_d;
    logic flag_q;
    logic clear_unused;

    // the disconnected path reads low, as the pad gate would
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else if (ce) begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            // history follows the raw line, so opening or closing the
            // input path is never mistaken for an edge
            prev_q  <= sync2_q;
        end
    end

    // ==========================================================
    // detection
    wire logic level = sync2_q & path_en;
    wire logic rise  = path_en & sync2_q & ~prev_q;
    wire logic fall  = path_en & ~sync2_q & prev_q;
    wire logic live  = enable & path_en;

    always_comb begin
        unique case (mode)
            EID_RISE:                   req_d = rise;
            EID_FALL, EID_FALL_ALT:     req_d = fall;
            EID_EITHER, EID_EITHER_ALT: req_d = rise | fall;
            EID_HIGH, EID_HIGH_ALT:     req_d = level;
            EID_LOW:                    req_d = path_en & ~level;
        endcase
        req_d = req_d & live;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_q <= 1'b0;
        end else if (ce) begin
            req_q <= req_d;
        end
    end

    assign req          = req_q;
    assign clear_unused = 1'b0;
    assign flag         = flag_q;

    // flag sets from req_d and never clears here: clear_unused is tied low, the parent keeps its own flags
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            flag_q <= req_d | (flag_q & ~clear_unused);
        end
    end

endmodule : eid_channel

// [tb/eid_src_model.sv]
// eid_src_model: external sources that drive the interrupt pins
// assumes: commands come from the bench one ns after the rising MCLK edge
`timescale 1ns/1ns
module eid_src_model
    import eid_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  go,
    input  wire logic [3:0]            ch,
    input  wire logic                  base,
    input  wire logic [7:0]            len,
    output logic [NUM_INPUTS-1:0]      pin
);
    logic [7:0] left_q = 8'h00;
    logic       noise_q = 1'b0;

    // ==========================================================
    // pulse source
    // unselected pins toggle every cycle so leaks between inputs show up
    always @(posedge clk) begin
        #2;
        if (go)
            left_q = len;
        else if (left_q != 8'h00)
            left_q = left_q - 8'h01;
        noise_q = ~noise_q;
        pin = {NUM_INPUTS{noise_q}};
        pin[ch] = (left_q != 8'h00) ? ~base : base;
    end
endmodule : eid_src_model

// [tb/external_interrupt_detector_tb.sv]
// external_interrupt_detector_tb: random self-checking bench for eid_detector
// assumes: eid_src_model drives the pins, MCLK at 125 MHz
`timescale 1ns/1ns
module external_interrupt_detector_tb;
    import eid_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        ce = 1'b1;
    logic        go = 1'b0;
    logic        base = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [9:0]  path = 10'h3ff;
    logic [9:0]  clr = 10'h000;
    logic [3:0]  ch = 4'h0;
    logic [7:0]  len = 8'h00;
    logic [9:0]  pin, req, flag;
    logic [15:0] lo, mi, hi;
    logic        wake;
    logic [47:0] cfg_exp = '0;
    logic [31:0] seed = 32'h80b2cb47;
    int          bad_count = 0;
    int          checked = 0;
    int          k, l;

    always #4 clk = ~clk;

    eid_detector dut (.MCLK(clk), .RESET(rst), .CE(ce),
        .EXT_IRQ_PIN(pin), .PIN_INPUT_PATH_ENABLE(path), .CFG_WR(wr),
        .CFG_SEL(sel), .CFG_WDATA(wdata), .EXT_IRQ_FLAG_CLEAR(clr),
        .EXT_IRQ_CONFIG_LOW(lo), .EXT_IRQ_CONFIG_MID(mi),
        .EXT_IRQ_CONFIG_HIGH(hi), .IRQ_REQ(req), .IRQ_FLAG(flag),
        .WAKE(wake));
    eid_src_model src (.clk(clk), .go(go), .ch(ch), .base(base),
        .len(len), .pin(pin));

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic int expc(input int m, input int n);
        case (m)
            0, 1, 5: return 1;
            2, 6: return 2;
            default: return n;
        endcase
    endfunction : expc

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic [1:0] s, input logic [15:0] d);
        sel = s;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        case (s)
            2'h0: cfg_exp[15:0] = d;
            2'h1: cfg_exp[31:16] = d;
            2'h2: cfg_exp[47:32] = {8'h00, d[7:0]};
            default: ;
        endcase
        tick(1);
        chk({hi, mi, lo}, cfg_exp);
    endtask : cfg

    // one input configured with the given enable, a single pulse against its idle level
    task automatic run(input logic [3:0] c, input logic [2:0] m,
                       input logic en, input logic pe, input int n,
                       input int e);
        logic [31:0] nr, no, nw;
        int i;
        ch = c;
        base = (m == 3'h4);
        len = 8'(n);
        path = 10'h3ff;
        path[c] = pe;
        nr = 0;
        no = 0;
        nw = 0;
        tick(4);
        for (i = 0; i < 3; i++)
            cfg(2'(i), (i == c / 4) ? 16'({en, m}) << (4 * (c % 4)) : 16'h0);
        clr = 10'h3ff;
        tick(1);
        clr = 10'h000;
        tick(5);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (i = 0; i < n + 12; i++) begin
            tick(1);
            nr = nr + 32'(req[c]);
            no = no + 32'((req & ~(10'h1 << c)) != 10'h0);
            nw = nw + 32'(wake);
        end
        chk(48'(nr), 48'(e));
        chk(48'(no), 48'h0);
        chk(48'(nw), 48'(e));
        chk(48'(flag[c]), 48'(e != 0));
        clr[c] = 1'b1;
        tick(1);
        clr = 10'h000;
        tick(1);
        chk(48'(flag[c]), 48'h0);
    endtask : run

    task automatic results();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // ==========================================================
    // scenarios
    initial begin
        tick(16);
        rst = 1'b0;
        tick(1);
        chk({hi, mi, lo}, 48'h0);
        chk(48'(req), 48'h0);
        for (k = 0; k < 8; k++)
            cfg(2'(rnd()), 16'(rnd()));
        // a write with the clock enable low must leave the words frozen
        ce = 1'b0;
        sel = 2'h0;
        wdata = 16'hffff;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
        chk({hi, mi, lo}, cfg_exp);
        ce = 1'b1;
        tick(1);
        for (k = 0; k < 8; k++) begin
            l = 2 + int'(rnd() % 6);
            run(4'(rnd() % 10), 3'(k), 1'b1, 1'b1, l, expc(k, l));
        end
        run(4'(rnd() % 10), 3'h0, 1'b0, 1'b1, 5, 0);
        run(4'(rnd() % 10), 3'h2, 1'b1, 1'b0, 5, 0);
        run(4'(rnd() % 10), 3'h4, 1'b1, 1'b0, 5, 0);
        results();
    end

    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule : external_interrupt_detector_tb
